/* File: logic/acc_pkg.sv */
`default_nettype none
package acc_pkg;
	// Geometry of the bank
	localparam int ACC_NUM_CH = 2;
	localparam int ACC_REG_W  = 16;
	localparam int ACC_ADDR_W = 8;
	localparam int ACC_DATA_W = 32;
	localparam int ACC_PH_W   = 10;
	localparam int ACC_CAL_W  = 24;

	// Register indices; byte address is four times the index
	localparam logic [5:0] ACC_IDX_CHAN0_CONFIG  = 6'h09;
	localparam logic [5:0] ACC_IDX_OCAL_HI  = 6'h0a;
	localparam logic [5:0] ACC_IDX_OCAL_LO  = 6'h0b;
	localparam logic [5:0] ACC_IDX_GCAL_HI  = 6'h0c;
	localparam logic [5:0] ACC_IDX_GCAL_LO  = 6'h0d;
	localparam logic [5:0] ACC_IDX_CHAN1_CONFIG  = 6'h0e;

	// Field positions inside a channel configuration word and a calibration lower word
	localparam int ACC_PHASE_LSB = 6;
	localparam int ACC_PHASE_MSB = 15;
	localparam int ACC_RSVD_LSB  = 3;
	localparam int ACC_RSVD_MSB  = 5;
	localparam int ACC_HPF_BIT   = 2;
	localparam int ACC_SEL_LSB   = 0;
	localparam int ACC_SEL_MSB   = 1;
	localparam int ACC_CAL_LO_LSB = 8;

	// Reset values
	localparam logic [15:0] ACC_CFG_RST     = 16'h0000;
	localparam logic [15:0] ACC_OCAL_HI_RST = 16'h0000;
	localparam logic [15:0] ACC_OCAL_LO_RST = 16'h0000;
	localparam logic [15:0] ACC_GCAL_HI_RST = 16'h8000;
	localparam logic [15:0] ACC_GCAL_LO_RST = 16'h0000;

	// Writable bits; everything else is read-only zero
	localparam logic [15:0] ACC_CFG_WMASK    = 16'hffc7;
	localparam logic [15:0] ACC_FULL_WMASK   = 16'hffff;
	localparam logic [15:0] ACC_CAL_LO_WMASK = 16'hff00;

	// Converter input choice
	typedef enum logic [1:0] {
		ACC_SEL_PINS     = 2'b00,
		ACC_SEL_SHORT    = 2'b01,
		ACC_SEL_POS_TEST = 2'b10,
		ACC_SEL_NEG_TEST = 2'b11
	} acc_input_sel_type;

	// Byte-lane merge of a write into a stored word
	function automatic logic [15:0] acc_merge(
		input logic [15:0] old_val,
		input logic [15:0] new_val,
		input logic [1:0]  be,
		input logic [15:0] wmask
	);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}} & wmask;
		return (old_val & ~m) | (new_val & m);
	endfunction
endpackage
`default_nettype wire

/* File: logic/acc_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Write strobe and readback between the bus decode and one channel's config word
interface acc_cfg_if;
	logic                         wr_en;
	logic [acc_pkg::ACC_REG_W-1:0] wdata;
	logic [1:0]                   be;
	logic [acc_pkg::ACC_REG_W-1:0] rdata;
	modport bank (output wr_en, output wdata, output be, input rdata);
	modport cfg  (input wr_en, input wdata, input be, output rdata);
endinterface
`default_nettype wire

/* File: logic/acc_chan_cfg.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_chan_cfg (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	acc_cfg_if.cfg                            bus,
	output logic [acc_pkg::ACC_PH_W-1:0]      phase_delay,
	output logic                              hpf_bypass,
	output var acc_pkg::acc_input_sel_type    input_select
);
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;

	// Reserved bits are masked off so they can never hold a one
	assign cfg_d = bus.wr_en ? acc_pkg::acc_merge(cfg_q, bus.wdata, bus.be, acc_pkg::ACC_CFG_WMASK) : cfg_q;

	// Config word, zero after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= acc_pkg::ACC_CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Field outputs straight from the stored word
	assign phase_delay  = cfg_q[acc_pkg::ACC_PHASE_MSB:acc_pkg::ACC_PHASE_LSB];
	assign hpf_bypass   = cfg_q[acc_pkg::ACC_HPF_BIT];
	assign input_select = acc_pkg::acc_input_sel_type'(cfg_q[acc_pkg::ACC_SEL_MSB:acc_pkg::ACC_SEL_LSB]);
	assign bus.rdata    = cfg_q;

	// Full-word write lands in the signed delay field
	property p_phase_write;
		@(posedge pclk) disable iff (!presetn)
		bus.wr_en && (&bus.be) |=> phase_delay == $past(bus.wdata[15:6]);
	endproperty
	a_phase_write: assert property (p_phase_write) else $error("phase delay not taken from write");

	// Bypass bit only moves on a low-byte write
	property p_hpf_hold;
		@(posedge pclk) disable iff (!presetn)
		!(bus.wr_en && bus.be[0]) |=> $stable(hpf_bypass);
	endproperty
	a_hpf_hold: assert property (p_hpf_hold) else $error("bypass bit changed without write");

	// Input choice follows the low byte write
	property p_sel_write;
		@(posedge pclk) disable iff (!presetn)
		bus.wr_en && bus.be[0] |=> input_select == $past(bus.wdata[1:0]) ##1 input_select == $past(input_select);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("input select not taken from write");

	// Reserved field reads zero even after ones are written
	property p_rsvd_zero;
		@(posedge pclk) disable iff (!presetn)
		bus.wr_en && bus.wdata[5:3] != 3'b000 |=> bus.rdata[5:3] == 3'b000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
endmodule
`default_nettype wire

/* File: logic/acc_cfg_cal_regs.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Each channel config holds a ten-bit signed phase delay in bits 15:6, reset zero.
// - Config bit 2 set bypasses that channel's DC block; clear follows the global corner.
// - Config bits 1:0 pick pins, shorted inputs, positive or negative test signal.
// - Offset is 24 bits: upper word gives bits 23:8, lower word bits 15:8 give bits 7:0; low byte reads zero.
// - Gain splits likewise; upper resets to 8000h, lower to zero.
// - Channel 0 offset upper, offset lower, gain upper, gain lower sit at indices Ah to Dh.
// - Channel 1 config at Eh has the same fields; its bits 5:3 read zero.
module acc_cfg_cal_regs (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [acc_pkg::ACC_ADDR_W-1:0]  paddr,
	input  wire logic [acc_pkg::ACC_DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic [acc_pkg::ACC_DATA_W-1:0]       prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	output logic [acc_pkg::ACC_PH_W-1:0]         chan0_phase_delay,
	output logic                                 chan0_hpf_bypass,
	output logic [1:0]                           chan0_input_select,
	output logic [acc_pkg::ACC_PH_W-1:0]         chan1_phase_delay,
	output logic                                 chan1_hpf_bypass,
	output logic [1:0]                           chan1_input_select,
	output logic [acc_pkg::ACC_CAL_W-1:0]        chan0_offset_cal,
	output logic [acc_pkg::ACC_CAL_W-1:0]        chan0_gain_cal
);
	localparam int NCH = acc_pkg::ACC_NUM_CH;

	// Bus phases
	logic setup;
	logic access;
	logic wr;
	logic any_hit;
	logic [1:0] be;
	logic [15:0] wdata16;

	// Address hits
	logic hit_ocal_hi;
	logic hit_ocal_lo;
	logic hit_gcal_hi;
	logic hit_gcal_lo;
	logic [NCH-1:0] hit_cfg;

	// Calibration words
	logic [15:0] ocal_hi_q;
	logic [15:0] ocal_hi_d;
	logic [15:0] ocal_lo_q;
	logic [15:0] ocal_lo_d;
	logic [15:0] gcal_hi_q;
	logic [15:0] gcal_hi_d;
	logic [15:0] gcal_lo_q;
	logic [15:0] gcal_lo_d;

	// Readback
	logic [15:0] ocal_lo_rd;
	logic [15:0] gcal_lo_rd;
	logic [15:0] rd_val;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        pslverr_q;
	logic        pslverr_d;

	// Per-channel config paths
	logic [15:0]             cfg_rd [NCH];
	logic [acc_pkg::ACC_PH_W-1:0] phase_w [NCH];
	logic                    hpf_w [NCH];
	acc_pkg::acc_input_sel_type sel_w [NCH];

	acc_cfg_if cfg_bus [NCH] ();

	// Phase decode; zero wait states, so every access phase completes at once
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign pready  = 1'b1;
	assign be      = pstrb[1:0];
	assign wdata16 = pwdata[15:0];
	assign wr      = access & pwrite & any_hit;

	// Full-address compare also rejects misaligned addresses
	assign hit_ocal_hi = paddr == {acc_pkg::ACC_IDX_OCAL_HI, 2'b00};
	assign hit_ocal_lo = paddr == {acc_pkg::ACC_IDX_OCAL_LO, 2'b00};
	assign hit_gcal_hi = paddr == {acc_pkg::ACC_IDX_GCAL_HI, 2'b00};
	assign hit_gcal_lo = paddr == {acc_pkg::ACC_IDX_GCAL_LO, 2'b00};
	assign hit_cfg[0]  = paddr == {acc_pkg::ACC_IDX_CHAN0_CONFIG, 2'b00};
	assign hit_cfg[1]  = paddr == {acc_pkg::ACC_IDX_CHAN1_CONFIG, 2'b00};
	assign any_hit     = hit_ocal_hi | hit_ocal_lo | hit_gcal_hi | hit_gcal_lo | (|hit_cfg);

	// One config slice per channel; both share the same layout
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			assign cfg_bus[i].wr_en = wr & hit_cfg[i];
			assign cfg_bus[i].wdata = wdata16;
			assign cfg_bus[i].be    = be;
			assign cfg_rd[i]        = cfg_bus[i].rdata;

			acc_chan_cfg u_cfg (
				.pclk         (pclk),
				.presetn      (presetn),
				.bus          (cfg_bus[i]),
				.phase_delay  (phase_w[i]),
				.hpf_bypass   (hpf_w[i]),
				.input_select (sel_w[i])
			);
		end
	endgenerate

	// Channel outputs
	assign chan0_phase_delay  = phase_w[0];
	assign chan0_hpf_bypass   = hpf_w[0];
	assign chan0_input_select = sel_w[0];
	assign chan1_phase_delay  = phase_w[1];
	assign chan1_hpf_bypass   = hpf_w[1];
	assign chan1_input_select = sel_w[1];

	// Next values of the calibration words; low words keep their low byte at zero
	assign ocal_hi_d = (wr & hit_ocal_hi) ? acc_pkg::acc_merge(ocal_hi_q, wdata16, be, acc_pkg::ACC_FULL_WMASK) : ocal_hi_q;
	assign ocal_lo_d = (wr & hit_ocal_lo) ? acc_pkg::acc_merge(ocal_lo_q, wdata16, be, acc_pkg::ACC_CAL_LO_WMASK) : ocal_lo_q;
	assign gcal_hi_d = (wr & hit_gcal_hi) ? acc_pkg::acc_merge(gcal_hi_q, wdata16, be, acc_pkg::ACC_FULL_WMASK) : gcal_hi_q;
	assign gcal_lo_d = (wr & hit_gcal_lo) ? acc_pkg::acc_merge(gcal_lo_q, wdata16, be, acc_pkg::ACC_CAL_LO_WMASK) : gcal_lo_q;

	// Offset calibration pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocal_hi_q <= acc_pkg::ACC_OCAL_HI_RST;
			ocal_lo_q <= acc_pkg::ACC_OCAL_LO_RST;
		end else begin
			ocal_hi_q <= ocal_hi_d;
			ocal_lo_q <= ocal_lo_d;
		end
	end

	// Gain calibration pair; unity-like reset word has only its top bit set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gcal_hi_q <= acc_pkg::ACC_GCAL_HI_RST;
			gcal_lo_q <= acc_pkg::ACC_GCAL_LO_RST;
		end else begin
			gcal_hi_q <= gcal_hi_d;
			gcal_lo_q <= gcal_lo_d;
		end
	end

	// Assembled 24-bit words for the datapath
	assign chan0_offset_cal = {ocal_hi_q, ocal_lo_q[15:acc_pkg::ACC_CAL_LO_LSB]};
	assign chan0_gain_cal   = {gcal_hi_q, gcal_lo_q[15:acc_pkg::ACC_CAL_LO_LSB]};

	// Low byte forced to zero on read, independent of storage
	assign ocal_lo_rd = {ocal_lo_q[15:8], 8'h00};
	assign gcal_lo_rd = {gcal_lo_q[15:8], 8'h00};

	// AND-OR read select; an unmapped address reads zero
	assign rd_val = ({16{hit_ocal_hi}} & ocal_hi_q)
		| ({16{hit_ocal_lo}} & ocal_lo_rd)
		| ({16{hit_gcal_hi}} & gcal_hi_q)
		| ({16{hit_gcal_lo}} & gcal_lo_rd)
		| ({16{hit_cfg[0]}} & cfg_rd[0])
		| ({16{hit_cfg[1]}} & cfg_rd[1]);

	// Read data is captured in setup so the access phase shows a flop output
	assign prdata_d  = (setup & ~pwrite) ? {16'h0000, rd_val} : prdata_q;
	assign pslverr_d = setup ? ~any_hit : pslverr_q;

	// Response registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Error only shown during the access phase it belongs to
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q & access;

	// Records whether the gain words have ever been written since reset
	logic gain_touched_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_touched_q <= 1'b0;
		end else if (wr & (hit_gcal_hi | hit_gcal_lo)) begin
			gain_touched_q <= 1'b1;
		end
	end

	// Read of a low calibration word in setup, then its access phase
	sequence s_rd_ocal_lo;
		setup && !pwrite && hit_ocal_lo ##1 access;
	endsequence

	// Full-width write to the gain upper word
	sequence s_wr_gain_hi;
		wr && hit_gcal_hi && be == 2'b11;
	endsequence

	// Read setup aimed at the gain upper word
	sequence s_rd_gain_hi;
		setup && !pwrite && hit_gcal_hi;
	endsequence

	// Low calibration byte always reads back zero, upper half too
	property p_ocal_lo_read;
		@(posedge pclk) disable iff (!presetn)
		s_rd_ocal_lo |-> prdata[7:0] == 8'h00 && prdata[15:8] == ocal_lo_q[15:8] && prdata[31:16] == 16'h0000;
	endproperty
	a_ocal_lo_read: assert property (p_ocal_lo_read) else $error("offset lower read wrong");

	// Lower word write lands in offset bits 7:0
	property p_ocal_split;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ocal_lo && be == 2'b11 |=> chan0_offset_cal[7:0] == $past(pwdata[15:8]) && $stable(chan0_offset_cal[23:8]);
	endproperty
	a_ocal_split: assert property (p_ocal_split) else $error("offset lower byte misplaced");

	// Untouched gain shows its reset word
	property p_gain_reset;
		@(posedge pclk) disable iff (!presetn)
		!gain_touched_q |-> chan0_gain_cal == 24'h800000;
	endproperty
	a_gain_reset: assert property (p_gain_reset) else $error("gain reset word wrong");

	// Write then read of gain upper returns the written word
	property p_gain_hi_decode;
		@(posedge pclk) disable iff (!presetn)
		s_wr_gain_hi ##1 s_rd_gain_hi |=> prdata[15:0] == $past(pwdata[15:0], 2);
	endproperty
	a_gain_hi_decode: assert property (p_gain_hi_decode) else $error("gain upper decode wrong");

	// Unmapped address answers with an error and changes nothing
	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		setup && !any_hit ##1 access |-> pslverr ##1 $stable(chan0_offset_cal) && $stable(chan0_gain_cal);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	// Read of the gain lower word in setup, then its access phase
	sequence s_rd_gcal_lo;
		setup && !pwrite && hit_gcal_lo ##1 access;
	endsequence

	// Read of the channel 1 config word in setup, then its access phase
	sequence s_rd_cfg1;
		setup && !pwrite && hit_cfg[1] ##1 access;
	endsequence

	// Gain lower word reads its stored byte over a zero low byte
	property p_gcal_lo_read;
		@(posedge pclk) disable iff (!presetn)
		s_rd_gcal_lo |-> prdata[7:0] == 8'h00 && prdata[15:8] == gcal_lo_q[15:8];
	endproperty
	a_gcal_lo_read: assert property (p_gcal_lo_read) else $error("gain lower read wrong");

	// Lower word write lands in gain bits 7:0 only
	property p_gcal_split;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_gcal_lo && be == 2'b11 |=> chan0_gain_cal[7:0] == $past(pwdata[15:8]) && $stable(chan0_gain_cal[23:8]);
	endproperty
	a_gcal_split: assert property (p_gcal_split) else $error("gain lower byte misplaced");

	// Upper word write lands in offset bits 23:8 only
	property p_ocal_hi_write;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_ocal_hi && be == 2'b11 |=> chan0_offset_cal[23:8] == $past(pwdata[15:0]) && $stable(chan0_offset_cal[7:0]);
	endproperty
	a_ocal_hi_write: assert property (p_ocal_hi_write) else $error("offset upper word misplaced");

	// Channel 1 config reads its phase field over zero reserved bits
	property p_cfg1_read;
		@(posedge pclk) disable iff (!presetn)
		s_rd_cfg1 |-> prdata[5:3] == 3'b000 && prdata[15:6] == chan1_phase_delay;
	endproperty
	a_cfg1_read: assert property (p_cfg1_read) else $error("channel 1 config read wrong");

	// A channel 1 config write leaves channel 0 alone
	property p_cfg_isolated;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_cfg[1] |=> $stable(chan0_phase_delay) && $stable(chan0_hpf_bypass) && $stable(chan0_input_select);
	endproperty
	a_cfg_isolated: assert property (p_cfg_isolated) else $error("channel 0 moved on channel 1 write");

	// A mapped access completes without error
	property p_mapped_ok;
		@(posedge pclk) disable iff (!presetn)
		setup && any_hit ##1 access |-> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged as error");

	// Read data only moves at a read setup edge, so a slow master still sees it
	property p_prdata_hold;
		@(posedge pclk) disable iff (!presetn)
		!(setup && !pwrite) |=> $stable(prdata);
	endproperty
	a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside read setup");

	// Zero wait states and a zero upper half in every access
	property p_access_ready;
		@(posedge pclk) disable iff (!presetn)
		access |-> pready && prdata[31:16] == 16'h0000;
	endproperty
	a_access_ready: assert property (p_access_ready) else $error("access not ready or upper half set");
endmodule
`default_nettype wire

/* File: test/acc_cfg_cal_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_cfg_cal_regs_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  chan0_phase_delay;
	logic        chan0_hpf_bypass;
	logic [1:0]  chan0_input_select;
	logic [9:0]  chan1_phase_delay;
	logic        chan1_hpf_bypass;
	logic [1:0]  chan1_input_select;
	logic [23:0] chan0_offset_cal;
	logic [23:0] chan0_gain_cal;
	int          errors;
	int          comparisons;
	int          cycles;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  addr_t [6];
	logic [15:0] rst_t  [6];
	logic [15:0] mask_t [6];

	acc_cfg_cal_regs dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan0_phase_delay(chan0_phase_delay), .chan0_hpf_bypass(chan0_hpf_bypass),
		.chan0_input_select(chan0_input_select), .chan1_phase_delay(chan1_phase_delay),
		.chan1_hpf_bypass(chan1_hpf_bypass), .chan1_input_select(chan1_input_select),
		.chan0_offset_cal(chan0_offset_cal), .chan0_gain_cal(chan0_gain_cal)
	);

	// Free-running 50 MHz clock
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// Cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; upper data lanes carry junk that must be ignored
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {~d, d};
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		xfer(1'b1, a, d, s);
		check("write error flag", 32'h0, {31'h0, err});
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
		xfer(1'b0, a, 16'h0000, 4'h0);
		check(name, {16'h0000, exp}, rd);
		check("read error flag", 32'h0, {31'h0, err});
	endtask

	// Write then read of one register with no idle cycle between the two transfers
	task automatic wr_rd_chk(input string name, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= 1'b1;
		paddr   <= a;
		pwdata  <= {~d, d};
		pstrb   <= 4'h3;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		check("back to back write error flag", 32'h0, {31'h0, pslverr});
		penable <= 1'b0;
		pwrite  <= 1'b0;
		pstrb   <= 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		check(name, {16'h0000, d}, rd);
		check("back to back read error flag", 32'h0, {31'h0, err});
	endtask

	task automatic final_report();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		// Order: ch0 config, offset upper, offset lower, gain upper, gain lower, ch1 config
		addr_t = '{{acc_pkg::ACC_IDX_CHAN0_CONFIG, 2'b00}, {acc_pkg::ACC_IDX_OCAL_HI, 2'b00},
			{acc_pkg::ACC_IDX_OCAL_LO, 2'b00}, {acc_pkg::ACC_IDX_GCAL_HI, 2'b00},
			{acc_pkg::ACC_IDX_GCAL_LO, 2'b00}, {acc_pkg::ACC_IDX_CHAN1_CONFIG, 2'b00}};
		rst_t  = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
		mask_t = '{16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00, 16'hffc7};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;

		// Reset values through the bus and at the gain output
		for (int i = 0; i < 6; i++) rd_chk("reset value", addr_t[i], rst_t[i]);
		check("gain at reset", 32'h00800000, {8'h00, chan0_gain_cal});
		$display("reset test done");

		// Writable and read-zero bits of every register
		for (int i = 0; i < 6; i++) begin
			wr(addr_t[i], 16'hffff, 4'h3);
			rd_chk("all ones", addr_t[i], mask_t[i]);
			wr(addr_t[i], 16'ha5a5, 4'h3);
			rd_chk("pattern", addr_t[i], 16'ha5a5 & mask_t[i]);
		end
		$display("access test done");

		// Every input choice, bypass both ways, phase at both signed extremes
		for (int k = 0; k < 4; k++) begin
			wr(addr_t[0], {10'h200, 3'b111, k[0], k[1:0]}, 4'h3);
			wr(addr_t[5], {10'h1ff, 3'b111, ~k[0], k[1:0]}, 4'h3);
			@(negedge pclk);
			check("ch0 phase", 32'h200, {22'h0, chan0_phase_delay});
			check("ch0 bypass", {31'h0, k[0]}, {31'h0, chan0_hpf_bypass});
			check("ch0 select", k, {30'h0, chan0_input_select});
			check("ch1 phase", 32'h1ff, {22'h0, chan1_phase_delay});
			check("ch1 bypass", {31'h0, ~k[0]}, {31'h0, chan1_hpf_bypass});
			check("ch1 select", k, {30'h0, chan1_input_select});
		end
		$display("field test done");

		// Calibration words assemble from upper word and lower byte
		wr(addr_t[1], 16'h1234, 4'h3);
		wr(addr_t[2], 16'habcd, 4'h3);
		wr(addr_t[3], 16'hfedc, 4'h3);
		wr(addr_t[4], 16'h5a77, 4'h3);
		@(negedge pclk);
		check("offset word", 32'h001234ab, {8'h00, chan0_offset_cal});
		check("gain word", 32'h00fedc5a, {8'h00, chan0_gain_cal});
		wr_rd_chk("gain upper back to back", addr_t[3], 16'h2468);
		$display("calibration test done");

		// Byte lanes, then refused addresses that must leave the bank alone
		wr(addr_t[5], 16'h0000, 4'h3);
		wr(addr_t[5], 16'hffff, 4'h2);
		rd_chk("upper lane", addr_t[5], 16'hff00);
		wr(addr_t[5], 16'hffff, 4'h1);
		rd_chk("lower lane", addr_t[5], 16'hffc7);
		wr(addr_t[5], 16'h0000, 4'hc);
		rd_chk("no lane", addr_t[5], 16'hffc7);
		xfer(1'b1, 8'h3c, 16'h1111, 4'h3);
		check("unmapped write error", 32'h1, {31'h0, err});
		xfer(1'b0, 8'h3c, 16'h0000, 4'h0);
		check("unmapped read error", 32'h1, {31'h0, err});
		check("unmapped read data", 32'h0, rd);
		xfer(1'b1, 8'h29, 16'h1111, 4'h3);
		check("misaligned error", 32'h1, {31'h0, err});
		rd_chk("offset untouched", addr_t[1], 16'h1234);
		$display("refusal test done");

		// Second reset in mid-run restores calibration defaults
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		check("gain in reset", 32'h00800000, {8'h00, chan0_gain_cal});
		check("offset in reset", 32'h0, {8'h00, chan0_offset_cal});
		check("ch1 phase in reset", 32'h0, {22'h0, chan1_phase_delay});
		@(posedge pclk);
		presetn <= 1'b1;
		rd_chk("gain upper after reset", addr_t[3], 16'h8000);
		$display("second reset test done");
		final_report();
	end
endmodule
`default_nettype wire
